// *** rtl/word_match_trigger_ctrl.v ***
// Purpose: Word-pattern trigger and precision-measurement resolution control
// Assumes: Probe pins asynchronous to ref_clk; measurement samples on ref_clk
// Notes:   Long counts are parameters so simulation can shorten them
//
// The register addresses and strobed register access are this design's own decisions.

`include "word_match_trigger_map.vh"

// Summary of operation
// [R1] Capture probed word on rising, falling clock edge, or continuously.
// [R2] Match output high while configured word is recognised, low otherwise.
// [R3] Match output keeps working once word defined, even when unused.
// [R4] Match follows selected clock edge, or input coincidence when clockless.
// [R5] Binary, octal and hexadecimal radices are selectable for the word.
// [R6] Octal or hex digits partly don't-care are flagged as ambiguous.
// [R7] Status shows trigger sweep, clock mode, qualifier, word in radix.
// [R8] Auto-level mode cancels logic trigger unless B sweep uses matcher.
// [R9] Resolutions: automatic, 1 ns, 100 ps and 10 ps.
// [R10] Auto updates at slower of half second or sample arrival.
// [R11] Fixed resolution updates only after enough sweeps accumulate.
// [R12] Sweep count depends on resolution and timebase, e.g. over 100.
// [R13] Command naming an unfitted option raises a service-request error.
// [R14] Setting reads return settings; measurements only via send register.
// [R15] Don't-care bits always match; others, qualifier too, are compared.
module word_match_trigger_ctrl #(
  parameter WR_FITTED = 1,
  parameter CTT_FITTED = 1,
  parameter AUTO_CYCLES = `AUTO_CYCLES,
  parameter SWEEPS_1E6 = `SWEEPS_1E6,
  parameter SWEEPS_1E4 = `SWEEPS_1E4
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [15:0] rdata,
  input wire probe_clk,
  input wire [15:0] probe_word,
  input wire probe_qual,
  input wire sweep_done,
  input wire meas_valid,
  input wire [15:0] meas_value,
  output reg word_match_r,
  output reg trig_a_r,
  output reg trig_b_r,
  output wire irq
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function mixed;
    input [3:0] bits;
    input [3:0] width_mask;
    begin
      mixed = ((bits & width_mask) != 4'h0) && ((bits & width_mask) != width_mask);
    end
  endfunction

  function [31:0] sweeps_needed;
    input [1:0] res;
    input [1:0] tb;
    begin
      if (tb == `TB_FAST && res == `RES_10PS) begin
        sweeps_needed = SWEEPS_1E6;
      end else if (tb == `TB_FAST && res == `RES_100PS) begin
        sweeps_needed = SWEEPS_1E4;
      end else if (tb == `TB_MID && res != `RES_1NS) begin
        sweeps_needed = SWEEPS_1E4;
      end else if (tb == `TB_COARSE) begin
        sweeps_needed = `SWEEPS_1;
      end else begin
        sweeps_needed = `SWEEPS_100;
      end
    end
  endfunction

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  reg [15:0] ctrl_r;
  reg [15:0] word_r;
  reg [15:0] care_r;
  reg [1:0] qual_cfg_r;
  reg word_defined_r;
  reg [`EVT_W-1:0] evt_r;
  reg [`EVT_W-1:0] evt_nxt;
  reg [`EVT_W-1:0] mask_r;
  reg [15:0] meas_r;
  reg meas_rdy_r;

  wire [1:0] radix = ctrl_r[`CTRL_RADIX_LSB+1:`CTRL_RADIX_LSB];
  wire [1:0] clk_mode = ctrl_r[`CTRL_CLK_LSB+1:`CTRL_CLK_LSB];
  wire trig_b_sel = ctrl_r[`CTRL_TRIG_B];
  wire logic_en = ctrl_r[`CTRL_LOGIC_EN];
  wire [1:0] res_sel = ctrl_r[`CTRL_RES_LSB+1:`CTRL_RES_LSB];
  wire [1:0] tb_sel = ctrl_r[`CTRL_TB_LSB+1:`CTRL_TB_LSB];

  wire wr_ctrl = wr_stb && addr == `OFS_CTRL;
  wire wr_word = wr_stb && addr == `OFS_WORD;
  wire wr_care = wr_stb && addr == `OFS_CARE;
  wire wr_qual = wr_stb && addr == `OFS_QUAL;
  wire wr_opt = wr_stb && addr == `OFS_OPT_CMD;
  wire rd_meas = rd_stb && addr == `OFS_MEAS;

  // Matcher writes on a build without it are refused and flagged
  wire wr_matcher = wr_word || wr_care || wr_qual;
  wire opt_missing = wr_opt &&
    ((wdata[1:0] == `OPT_WR && WR_FITTED == 0) ||
     (wdata[1:0] == `OPT_CTT && CTT_FITTED == 0));
  wire srq_err = opt_missing || (wr_matcher && WR_FITTED == 0);   // [R13]

  // Auto-level request drops the logic trigger unless B sweep is on the matcher
  wire auto_level_trigger_mode = wr_ctrl && wdata[`CTRL_AUTO_LEVEL_TRIGGER_MODE];
  wire keep_logic = trig_b_sel && logic_en;
  wire cancel_logic = auto_level_trigger_mode && logic_en && !keep_logic;       // [R8]

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_r <= `CTRL_RESET;
      word_r <= 16'h0000;
      care_r <= 16'h0000;
      qual_cfg_r <= 2'h0;
      word_defined_r <= 1'b0;
      mask_r <= {`EVT_W{1'b0}};
    end else begin
      if (wr_ctrl) begin
        // Auto-level bit is an action, never stored
        ctrl_r <= {5'h00, wdata[10:0] & 11'h3ff};
        if (cancel_logic) begin
          ctrl_r[`CTRL_LOGIC_EN] <= 1'b0;                        // [R8]
        end
      end
      if (WR_FITTED != 0) begin
        if (wr_word) begin
          word_r <= wdata;
          word_defined_r <= 1'b1;                                // [R3]
        end
        if (wr_care) begin
          care_r <= wdata;
        end
        if (wr_qual) begin
          qual_cfg_r <= wdata[1:0];
        end
      end
      if (wr_stb && addr == `OFS_EVT_MASK) begin
        mask_r <= wdata[`EVT_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Probe synchronisers
  // ----------------------------------------
  // Three stages; value accepted only once stages two and three agree
  reg [17:0] s1_r;
  reg [17:0] s2_r;
  reg [17:0] s3_r;
  reg [17:0] filt_r;
  reg pclk_prev_r;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_r <= 18'h00000;
      s2_r <= 18'h00000;
      s3_r <= 18'h00000;
      filt_r <= 18'h00000;
      pclk_prev_r <= 1'b0;
    end else begin
      s1_r <= {probe_clk, probe_qual, probe_word};
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
      pclk_prev_r <= filt_r[17];
    end
  end

  wire pclk = filt_r[17];
  wire rise = pclk && !pclk_prev_r;
  wire fall = !pclk && pclk_prev_r;

  reg sample;
  always @* begin
    case (clk_mode)
      `CLK_RISE: sample = rise;                                  // [R1]
      `CLK_FALL: sample = fall;                                  // [R1]
      `CLK_ASYNC: sample = 1'b1;                                 // [R1]
      default: sample = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Matcher
  // ----------------------------------------
  wire hit;

  word_compare u_cmp (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sample(sample),
    .data(filt_r[15:0]),
    .qual(filt_r[16]),
    .target(word_r),
    .care(care_r),
    .qual_level(qual_cfg_r[0]),
    .qual_care(qual_cfg_r[1]),
    .hit_r(hit)
  );

  // Fixed latency: edge detect plus compare plus output stage.
  // Independent of logic_en so the output stays live when unused.
  wire match_rise = hit && word_defined_r && !word_match_r;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      word_match_r <= 1'b0;
      trig_a_r <= 1'b0;
      trig_b_r <= 1'b0;
    end else begin
      word_match_r <= hit && word_defined_r;                     // [R2] [R3] [R4]
      trig_a_r <= match_rise && logic_en && !trig_b_sel;
      trig_b_r <= match_rise && logic_en && trig_b_sel;
    end
  end

  // ----------------------------------------
  // Display helpers
  // ----------------------------------------
  // Octal needs six digits for sixteen bits; top digit holds one bit
  reg [5:0] ambig;
  always @* begin
    case (radix)
      `RADIX_HEX: ambig = {2'h0,
        mixed(care_r[15:12], 4'hf), mixed(care_r[11:8], 4'hf),
        mixed(care_r[7:4], 4'hf), mixed(care_r[3:0], 4'hf)};     // [R6]
      `RADIX_OCT: ambig = {1'b0,
        mixed({1'b0, care_r[14:12]}, 4'h7),
        mixed({1'b0, care_r[11:9]}, 4'h7),
        mixed({1'b0, care_r[8:6]}, 4'h7),
        mixed({1'b0, care_r[5:3]}, 4'h7),
        mixed({1'b0, care_r[2:0]}, 4'h7)};                       // [R6]
      default: ambig = 6'h00;                                    // [R5]
    endcase
  end

  // ----------------------------------------
  // Resolution and update pacing
  // ----------------------------------------
  reg [31:0] sweep_cnt_r;
  reg [31:0] auto_cnt_r;
  reg half_sec_r;
  reg sample_seen_r;
  reg [15:0] last_meas_r;
  reg sweep_prev_r;

  wire sweep_evt = sweep_done && !sweep_prev_r;
  wire [31:0] need = sweeps_needed(res_sel, tb_sel);             // [R12]
  wire auto_mode = res_sel == `RES_AUTO;                         // [R9]
  wire auto_tick = auto_cnt_r == AUTO_CYCLES - 1;
  wire half_done = half_sec_r || auto_tick;
  wire got_sample = sample_seen_r || meas_valid;
  // Slower of the two: both must have happened
  wire auto_upd = auto_mode && half_done && got_sample;          // [R10]
  wire fix_upd = !auto_mode && sweep_evt && sweep_cnt_r + 32'd1 >= need; // [R11]
  wire update = auto_upd || fix_upd;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      sweep_cnt_r <= 32'd0;
      auto_cnt_r <= 32'd0;
      half_sec_r <= 1'b0;
      sample_seen_r <= 1'b0;
      last_meas_r <= 16'h0000;
      sweep_prev_r <= 1'b0;
      meas_r <= 16'h0000;
      meas_rdy_r <= 1'b0;
    end else begin
      sweep_prev_r <= sweep_done;
      if (meas_valid) begin
        last_meas_r <= meas_value;
      end
      if (wr_ctrl || update) begin
        // New setting restarts accumulation
        sweep_cnt_r <= 32'd0;
        auto_cnt_r <= 32'd0;
        half_sec_r <= 1'b0;
        sample_seen_r <= 1'b0;
      end else begin
        if (sweep_evt) begin
          sweep_cnt_r <= sweep_cnt_r + 32'd1;
        end
        auto_cnt_r <= auto_tick ? 32'd0 : auto_cnt_r + 32'd1;
        half_sec_r <= half_done;
        sample_seen_r <= got_sample;
      end
      if (update) begin
        meas_r <= meas_valid ? meas_value : last_meas_r;
      end
      // Each result is sent once; fresh update wins over read
      if (update) begin
        meas_rdy_r <= 1'b1;
      end else if (rd_meas) begin
        meas_rdy_r <= 1'b0;                                      // [R14]
      end
    end
  end

  // ----------------------------------------
  // Events and interrupt
  // ----------------------------------------
  always @* begin
    evt_nxt = evt_r;
    if (wr_stb && addr == `OFS_EVT) begin
      evt_nxt = evt_nxt & ~wdata[`EVT_W-1:0];
    end
    // Set after clear so a coincident event is kept
    if (match_rise) evt_nxt[`EVT_MATCH] = 1'b1;
    if (update) evt_nxt[`EVT_UPDATE] = 1'b1;
    if (srq_err) evt_nxt[`EVT_SRQ] = 1'b1;                       // [R13]
    if (cancel_logic) evt_nxt[`EVT_MENU] = 1'b1;                 // [R8]
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      evt_r <= {`EVT_W{1'b0}};
    end else begin
      evt_r <= evt_nxt;
    end
  end

  assign irq = |(evt_r & mask_r);

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (rd_stb) begin
      case (addr)
        `OFS_CTRL: rdata <= ctrl_r;                              // [R14]
        `OFS_WORD: rdata <= word_r;
        `OFS_CARE: rdata <= care_r;
        `OFS_QUAL: rdata <= {14'h0000, qual_cfg_r};
        `OFS_WR_STATUS: rdata <= {9'h000, radix, qual_cfg_r[0],
          clk_mode, trig_b_sel, word_defined_r};                 // [R7]
        `OFS_AMBIG: rdata <= {10'h000, ambig};
        `OFS_MEAS: rdata <= meas_r;                              // [R14]
        `OFS_MEAS_RDY: rdata <= {15'h0000, meas_rdy_r};
        `OFS_EVT: rdata <= {12'h000, evt_r};
        `OFS_EVT_MASK: rdata <= {12'h000, mask_r};
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

endmodule // word_match_trigger_ctrl

// *** rtl/word_match_trigger_map.vh ***
// Purpose: Constants for the word-match trigger and resolution control
// Assumes: 16-bit probed word, 20 MHz ref_clk
// Notes:   Offsets are word indices on the plain register port
`ifndef WORD_MATCH_TRIGGER_MAP_VH
`define WORD_MATCH_TRIGGER_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_CTRL      4'h0
`define OFS_WORD      4'h1
`define OFS_CARE      4'h2
`define OFS_QUAL      4'h3
`define OFS_WR_STATUS 4'h4
`define OFS_AMBIG     4'h5
`define OFS_MEAS      4'h6
`define OFS_MEAS_RDY  4'h7
`define OFS_EVT       4'h8
`define OFS_EVT_MASK  4'h9
`define OFS_OPT_CMD   4'ha

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define CTRL_RADIX_LSB 0
`define CTRL_CLK_LSB   2
`define CTRL_TRIG_B    4
`define CTRL_LOGIC_EN  5
`define CTRL_RES_LSB   6
`define CTRL_TB_LSB    8
`define CTRL_AUTO_LEVEL_TRIGGER_MODE  10
`define CTRL_RESET     16'h0000

// Radix, clock mode, resolution, timebase codes
`define RADIX_BIN  2'h0
`define RADIX_OCT  2'h1
`define RADIX_HEX  2'h2
`define CLK_RISE   2'h0
`define CLK_FALL   2'h1
`define CLK_ASYNC  2'h2
`define RES_AUTO   2'h0
`define RES_1NS    2'h1
`define RES_100PS  2'h2
`define RES_10PS   2'h3
`define TB_FAST    2'h0
`define TB_MID     2'h1
`define TB_SLOW    2'h2
`define TB_COARSE  2'h3

// Event bits
`define EVT_MATCH  0
`define EVT_UPDATE 1
`define EVT_SRQ    2
`define EVT_MENU   3
`define EVT_W      4

// Option command codes
`define OPT_CTT 2'h0
`define OPT_WR  2'h1

// ----------------------------------------
// Timing and sweep counts
// ----------------------------------------
`define CLK_HZ          20000000
`define AUTO_PERIOD_MS  500
`define AUTO_CYCLES     ((`CLK_HZ / 1000) * `AUTO_PERIOD_MS)
`define SWEEPS_1E6      1000001
`define SWEEPS_1E4      10001
`define SWEEPS_100      32'd101
`define SWEEPS_1        32'd2

`endif

// *** rtl/word_compare.v ***
// Purpose: Masked comparison of the probed word and qualifier
// Assumes: Inputs already synchronised to ref_clk
// Notes:   Result is registered, one cycle after the sample strobe

module word_compare (
  input wire ref_clk,
  input wire rst_n,
  input wire sample,
  input wire [15:0] data,
  input wire qual,
  input wire [15:0] target,
  input wire [15:0] care,
  input wire qual_level,
  input wire qual_care,
  output reg hit_r
);

  // Cleared care bits never take part
  wire word_ok = ((data ^ target) & care) == 16'h0000;           // [R15]
  wire qual_ok = !qual_care || (qual == qual_level);             // [R15]

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      hit_r <= 1'b0;
    end else if (sample) begin
      hit_r <= word_ok && qual_ok;                               // [R2]
    end
  end

endmodule // word_compare

// *** verification/word_match_trigger_ctrl_sva.sv ***
// Purpose: Port checker for the word-match trigger block
// Assumes: One ref_clk domain, rst_n synchronous active low
// Notes:   Bound to every instance of the block
`include "word_match_trigger_map.vh"
module word_match_trigger_ctrl_sva (
  input wire ref_clk,
  input wire rst_n,
  input wire [3:0] addr,
  input wire wr_stb,
  input wire rd_stb,
  input wire [15:0] rdata,
  input wire probe_clk,
  input wire [15:0] probe_word,
  input wire probe_qual,
  input wire word_match_r,
  input wire trig_a_r,
  input wire trig_b_r,
  input wire irq
);
  // ----------------------------------------
  // Cycles since pins or registers last moved
  // ----------------------------------------
  reg [17:0] pins_r;
  reg [3:0] quiet_r;
  always @(posedge ref_clk) begin
    pins_r <= {probe_clk, probe_qual, probe_word};
    if (!rst_n || wr_stb || pins_r != {probe_clk, probe_qual, probe_word}) begin
      quiet_r <= 4'h0;
    end else if (quiet_r != 4'hf) begin
      quiet_r <= quiet_r + 4'h1;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  rdata_idle_a: assert property (!$past(rd_stb) |-> rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  unmapped_zero_a: assert property (
    $past(rd_stb) && $past(addr) > `OFS_OPT_CMD |-> rdata == 16'h0000)
    else $error("unmapped read returned data");
  status_width_a: assert property (
    $past(rd_stb) && $past(addr) == `OFS_WR_STATUS |-> rdata[15:7] == 9'h000)
    else $error("status read has stray upper bits");
  match_latency_a: assert property ($changed(word_match_r) |-> quiet_r < 4'ha)
    else $error("match changed without recent cause");
  trig_a_pulse_a: assert property (trig_a_r |-> $rose(word_match_r) ##1 !trig_a_r)
    else $error("sweep A trigger not a pulse at match rise");
  trig_b_pulse_a: assert property (trig_b_r |-> $rose(word_match_r) ##1 !trig_b_r)
    else $error("sweep B trigger not a pulse at match rise");
  trig_excl_a: assert property (!(trig_a_r && trig_b_r))
    else $error("both sweeps triggered at once");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr_stb))
    else $error("interrupt dropped without a write");
endmodule // word_match_trigger_ctrl_sva

bind word_match_trigger_ctrl word_match_trigger_ctrl_sva i_sva (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .addr(addr),
  .wr_stb(wr_stb),
  .rd_stb(rd_stb),
  .rdata(rdata),
  .probe_clk(probe_clk),
  .probe_word(probe_word),
  .probe_qual(probe_qual),
  .word_match_r(word_match_r),
  .trig_a_r(trig_a_r),
  .trig_b_r(trig_b_r),
  .irq(irq)
);

// *** verification/probe_circuit_model.sv ***
// Purpose: Circuit under test feeding word, qualifier and clock
// Assumes: Clock toggles every 200 ns only while run is high
// Notes:   Word changes only while the clock stands still
module probe_circuit_model (
  input wire run,
  input wire [15:0] word_in,
  input wire qual_in,
  output logic probe_clk,
  output wire [15:0] probe_word,
  output wire probe_qual
);
  timeunit 1ns;
  timeprecision 1ns;
  initial probe_clk = 1'b0;
  // Parks at its last level between frames
  always begin
    wait (run);
    #200;
    if (run) begin
      probe_clk = ~probe_clk;
    end
  end
  assign probe_word = word_in;
  assign probe_qual = qual_in;
endmodule // probe_circuit_model

// *** verification/word_match_trigger_ctrl_test.sv ***
// Purpose: Self-checking bench for the word-match trigger block
// Assumes: Shortened auto period and sweep counts
// Notes:   Second instance lacks the counter option
module word_match_trigger_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, rst_n, wr_stb, rd_stb, sweep_done, meas_valid, run, qual_in, rd_seen;
  logic [3:0] addr;
  logic [15:0] wdata, meas_value, word_in, w, v;
  wire [15:0] rdata, probe_word;
  wire probe_clk, probe_qual, word_match_r, trig_a_r, trig_b_r, irq, irq2;
  int mismatches, checked, cycles, trig_cnt, trig_a_cnt;
  logic [15:0] exp_q[$];
  logic [15:0] amb[3] = '{16'h0000, 16'h0006, 16'h0002};
  logic [15:0] res_tab[6] = '{16'h0340, 16'h00c0, 16'h0080, 16'h0040, 16'h01c0, 16'h02c0};
  int n_tab[6] = '{2, 20, 10, 101, 10, 101};

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  word_match_trigger_ctrl #(.AUTO_CYCLES(50), .SWEEPS_1E6(20), .SWEEPS_1E4(10)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .probe_clk(probe_clk), .probe_word(probe_word),
    .probe_qual(probe_qual), .sweep_done(sweep_done), .meas_valid(meas_valid),
    .meas_value(meas_value), .word_match_r(word_match_r), .trig_a_r(trig_a_r),
    .trig_b_r(trig_b_r), .irq(irq));
  word_match_trigger_ctrl #(.CTT_FITTED(0), .AUTO_CYCLES(50)) i_dut2 (
    .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(), .probe_clk(probe_clk), .probe_word(probe_word),
    .probe_qual(probe_qual), .sweep_done(sweep_done), .meas_valid(meas_valid),
    .meas_value(meas_value), .word_match_r(), .trig_a_r(), .trig_b_r(), .irq(irq2));
  probe_circuit_model i_probe (.run(run), .word_in(word_in), .qual_in(qual_in),
    .probe_clk(probe_clk), .probe_word(probe_word), .probe_qual(probe_qual));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Read answers stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rd_seen) check(rdata, exp_q.pop_front());
    rd_seen <= rd_stb;
    cycles++;
    if (trig_b_r === 1'b1) trig_cnt++;
    if (trig_a_r === 1'b1) trig_a_cnt++;
    if (cycles == 6000) begin
      mismatches++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    rd_stb <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge ref_clk);
    rd_stb <= 1'b0;
  endtask

  // Synchroniser plus compare settle well inside 12 cycles
  task automatic wait_match(input logic e);
    repeat (12) @(posedge ref_clk);
    check({15'h0000, word_match_r}, {15'h0000, e});
  endtask

  task automatic step();
    run <= 1'b1;
    @(probe_clk);
    @(posedge ref_clk);
    run <= 1'b0;
  endtask

  task automatic sweeps(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      sweep_done <= 1'b1;
      @(posedge ref_clk);
      sweep_done <= 1'b0;
    end
  endtask

  task automatic sample(input logic [15:0] d);
    @(posedge ref_clk);
    meas_value <= d;
    meas_valid <= 1'b1;
    @(posedge ref_clk);
    meas_valid <= 1'b0;
  endtask

  initial begin
    {rst_n, wr_stb, rd_stb, sweep_done, meas_valid, run, qual_in} = 7'h00;
    {addr, wdata, meas_value, word_in} = 52'h0;
    void'($urandom(4));
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`OFS_CTRL, 16'h0000);
    rd(`OFS_WR_STATUS, 16'h0000);
    rd(4'hf, 16'h0000);
    wr(`OFS_CTRL, 16'h0008);
    wait_match(1'b0);
    w = 16'($urandom());
    wr(`OFS_WORD, w);
    wr(`OFS_CARE, 16'hffff);
    wr(`OFS_QUAL, 16'h0000);
    word_in <= w;
    wait_match(1'b1);
    word_in <= w ^ 16'h0001;
    wait_match(1'b0);
    wr(`OFS_CARE, 16'hfffe);
    wait_match(1'b1);
    wr(`OFS_QUAL, 16'h0003);
    wait_match(1'b0);
    qual_in <= 1'b1;
    wait_match(1'b1);
    // Clocked modes: only the chosen edge captures; sweep A armed first
    wr(`OFS_CTRL, 16'h0020);
    word_in <= w ^ 16'h0002;
    step();
    wait_match(1'b0);
    word_in <= w;
    step();
    wait_match(1'b0);
    step();
    wait_match(1'b1);
    wr(`OFS_EVT, 16'hffff);
    wr(`OFS_EVT_MASK, 16'h0001);
    wr(`OFS_CTRL, 16'h0034);
    word_in <= w ^ 16'h0002;
    step();
    wait_match(1'b0);
    word_in <= w;
    step();
    wait_match(1'b0);
    step();
    wait_match(1'b1);
    check(16'(trig_cnt), 16'h0001);
    check(16'(trig_a_cnt), 16'h0001);
    check({15'h0000, irq}, 16'h0001);
    rd(`OFS_WR_STATUS, 16'h0017);
    wr(`OFS_EVT, 16'h0001);
    @(posedge ref_clk);
    check({15'h0000, irq}, 16'h0000);
    wr(`OFS_CARE, 16'h0f30);
    for (int r = 0; r < 3; r++) begin
      wr(`OFS_CTRL, 16'(r));
      rd(`OFS_AMBIG, amb[r]);
      rd(`OFS_WR_STATUS, 16'h0011 | 16'(r << 5));
    end
    wr(`OFS_EVT, 16'hffff);
    // Logic trigger must already be active for auto-level to cancel it
    wr(`OFS_CTRL, 16'h0020);
    wr(`OFS_CTRL, 16'h0420);
    rd(`OFS_CTRL, 16'h0000);
    rd(`OFS_EVT, 16'h0008);
    wr(`OFS_EVT, 16'hffff);
    wr(`OFS_CTRL, 16'h0030);
    wr(`OFS_CTRL, 16'h0430);
    rd(`OFS_CTRL, 16'h0030);
    rd(`OFS_EVT, 16'h0000);
    wr(`OFS_EVT, 16'hffff);
    wr(`OFS_EVT_MASK, 16'h0004);
    wr(`OFS_OPT_CMD, {14'h0000, `OPT_WR});
    wr(`OFS_OPT_CMD, {14'h0000, `OPT_CTT});
    @(posedge ref_clk);
    check({15'h0000, irq}, 16'h0000);
    check({15'h0000, irq2}, 16'h0001);
    for (int i = 0; i < 6; i++) begin
      v = 16'($urandom());
      wr(`OFS_CTRL, res_tab[i]);
      sample(v);
      sweeps(n_tab[i] - 1);
      rd(`OFS_MEAS_RDY, 16'h0000);
      sweeps(1);
      rd(`OFS_MEAS_RDY, 16'h0001);
      rd(`OFS_MEAS, v);
      rd(`OFS_MEAS_RDY, 16'h0000);
    end
    wr(`OFS_CTRL, 16'h0000);
    repeat (120) @(posedge ref_clk);
    rd(`OFS_MEAS_RDY, 16'h0000);
    v = 16'($urandom());
    sample(v);
    repeat (60) @(posedge ref_clk);
    rd(`OFS_MEAS_RDY, 16'h0001);
    rd(`OFS_MEAS, v);
    repeat (3) @(posedge ref_clk);
    wrap_up();
  end
endmodule // word_match_trigger_ctrl_test
